// File: hw/stmt_defs.svh
`ifndef STMT_DEFS_SVH
`define STMT_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define STMT_CLK_MHZ 40
`define STMT_FRAME_US 125
`define STMT_ACTION_US 250
`define STMT_ACTION_CYCLES (`STMT_ACTION_US * `STMT_CLK_MHZ)
`define STMT_SECOND_CYCLES (1000000 * `STMT_CLK_MHZ)

// ----------------------------------------
// frame layout, zero based row and column
// ----------------------------------------
`define STMT_LAST_ROW 4'h8
`define STMT_LAST_COL 11'h437
`define STMT_LAST_LANE 4'hB
`define STMT_RSOH_ROWS 4'h3
`define STMT_OH_COLS 11'h024
`define STMT_B2_ROW 4'h4
`define STMT_B2_LAST_COL 11'h00B
`define STMT_K2_ROW 4'h4
`define STMT_K2_COL 11'h018
`define STMT_M1_ROW 4'h8
`define STMT_M1_COL 11'h00E

// ----------------------------------------
// codes
// ----------------------------------------
`define STMT_MAX_REI 7'h60
`define STMT_K2_AIS 3'h7
`define STMT_K2_RDI 3'h6
`define STMT_K2_NORMAL 3'h0
`define STMT_ALL_ONES 8'hFF
`define STMT_MIN_PERSIST 3'h3
`define STMT_MAX_PERSIST 3'h5

// ----------------------------------------
// register offsets
// ----------------------------------------
`define STMT_ADDR_CTRL 8'h00
`define STMT_ADDR_DEG 8'h04
`define STMT_ADDR_STATUS 8'h08
`define STMT_ADDR_NEAR_EBC 8'h0C
`define STMT_ADDR_FAR_EBC 8'h10
`define STMT_ADDR_DS 8'h14
`define STMT_ADDR_IRQ 8'h18
`define STMT_ADDR_MASK 8'h1C

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define STMT_CTRL_MON 0
`define STMT_CTRL_RING 1
`define STMT_CTRL_AIS_REP 2
`define STMT_CTRL_RDI_REP 3
`define STMT_CTRL_SSF_REP 4
`define STMT_CTRL_PERSIST_MSB 10
`define STMT_CTRL_PERSIST_LSB 8
`define STMT_CTRL_RESET 32'h0000031D
`define STMT_DEG_THR_MSB 15
`define STMT_DEG_WIN_MSB 19
`define STMT_DEG_WIN_LSB 16
`define STMT_DEG_RESET 32'h00030010
`define STMT_IRQ_SECOND 0
`define STMT_IRQ_AIS 1
`define STMT_IRQ_RDI 2
`define STMT_IRQ_DEG 3
`define STMT_IRQ_MSB 3

`endif

// File: hw/stmt_pkg.sv
package stmt_pkg;
	typedef logic [7:0] stmt_byte_t;
	typedef logic [11:0][7:0] stmt_bip_t;
	typedef struct packed {
		logic linkClk;
		logic frame;
		logic [7:0] data;
	} stmt_link_s;
	typedef struct packed {
		logic [3:0] cnt;
		logic flag;
	} stmt_filt_s;
endpackage

// File: hw/stmt_frame_bip.sv
`include "stmt_defs.svh"
module stmt_frame_bip (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// byte stream
	input wire logic strobe,
	input wire logic frameStart,
	input stmt_pkg::stmt_byte_t data,
	// position of current byte
	output logic [3:0] row,
	output logic [10:0] col,
	output logic [3:0] lane,
	// parity of previous frame
	output stmt_pkg::stmt_bip_t prevParity
);
	import stmt_pkg::*;

	logic [3:0] posRow, next_posRow, posLane, next_posLane;
	logic [10:0] posCol, next_posCol;
	stmt_bip_t acc, next_acc, next_prevParity;

	function automatic logic inRsoh(logic [3:0] r, logic [10:0] c);
		return (r < `STMT_RSOH_ROWS) && (c < `STMT_OH_COLS);
	endfunction

	always_comb begin
		row = frameStart ? 4'h0 : posRow;
		col = frameStart ? 11'h000 : posCol;
		lane = frameStart ? 4'h0 : posLane;
		next_posRow = posRow;
		next_posCol = posCol;
		next_posLane = posLane;
		next_acc = acc;
		next_prevParity = prevParity;
		if (strobe) begin
			if (col == `STMT_LAST_COL) begin
				next_posCol = 11'h000;
				next_posLane = 4'h0;
				next_posRow = (row == `STMT_LAST_ROW) ? 4'h0 : row + 4'h1;
			end else begin
				next_posCol = col + 11'h001;
				next_posLane = (lane == `STMT_LAST_LANE) ? 4'h0 : lane + 4'h1;
				next_posRow = row;
			end
			// even interleaved parity, overhead of the regenerator section left out
			if (frameStart) begin
				next_prevParity = acc;
				next_acc = '0;
			end else if (!inRsoh(row, col)) begin
				next_acc[lane] = acc[lane] ^ data;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			posRow <= 4'h0;
			posCol <= 11'h000;
			posLane <= 4'h0;
			acc <= '0;
			prevParity <= '0;
		end else begin
			posRow <= next_posRow;
			posCol <= next_posCol;
			posLane <= next_posLane;
			acc <= next_acc;
			prevParity <= next_prevParity;
		end
	end
endmodule

// File: hw/stmt_ms_trail.sv
// How it works
// (RULE_01) both directions carry octets in 125 us frames with their own clock and frame start
// (RULE_02) source writes sink's per-frame errored block count, 0 to 96, into M1
// (RULE_03) remote defect active forces K2 bits 6-8 to 110 within 250 us
// (RULE_04) after remote defect clears, K2 bits 6-8 pass through, 111 and 110 excepted
// (RULE_05) without remote defect, incoming 111 or 110 in K2 becomes 000
// (RULE_06) ring mode passes K2 bits transparently; otherwise 111 and 110 never leave; here remote defect still forces 110 in ring mode and otherwise
// (RULE_07) source places even interleaved parity of previous frame into twelve B2 bytes
// (RULE_08) sink checks B2 against own parity; each differing bit is one errored block
// (RULE_09) sink reads M1 bits 2-8 as far-end count; 97 to 127 mean zero
// (RULE_10) sink takes K2 pattern 110 as remote defect, others as normal
// (RULE_11) alarm defect set and cleared after x consecutive frames, x from 3 to 5
// (RULE_12) alarm action forces sink output to all ones, and releases it, within 250 us
// (RULE_13) reports are gated by monitoring, server fail and their own enables; only the AIS report checks server fail here, degrade has no enable
// (RULE_14) each second: near and far defect seconds and summed errored blocks
// (RULE_15) alarm defect drives action, remote defect, trail fail; degrade drives degrade output
// (RULE_16) degraded defect uses error threshold and seconds window on a one-second tick
//
// Design decisions made here: the APB register port and the register addresses.
`include "stmt_defs.svh"
module stmt_ms_trail #(
	parameter int unsigned SECOND_CYCLES = `STMT_SECOND_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// source direction
	input stmt_pkg::stmt_link_s soInLink,
	output stmt_pkg::stmt_byte_t soOutData,
	output logic soOutFrame,
	output logic soOutStrobe,
	// sink direction
	input stmt_pkg::stmt_link_s skInLink,
	input wire logic incomingServerFail,
	output stmt_pkg::stmt_byte_t skOutData,
	output logic skOutFrame,
	output logic skOutStrobe,
	output logic trailFailAction,
	output logic trailDegradeAction
);
	import stmt_pkg::*;

	localparam logic [31:0] SEC_LAST = 32'(SECOND_CYCLES - 1);

	// ----------------------------------------
	// link sampling
	// ----------------------------------------
	stmt_link_s soSync1, soSync2, soSync3, skSync1, skSync2, skSync3;
	logic ssfSync1, ssfSync2;
	logic soStrobe, skStrobe;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soSync1 <= '0;
			soSync2 <= '0;
			soSync3 <= '0;
			skSync1 <= '0;
			skSync2 <= '0;
			skSync3 <= '0;
			ssfSync1 <= 1'b0;
			ssfSync2 <= 1'b0;
		end else begin
			soSync1 <= soInLink;
			soSync2 <= soSync1;
			soSync3 <= soSync2;
			skSync1 <= skInLink;
			skSync2 <= skSync1;
			skSync3 <= skSync2;
			ssfSync1 <= incomingServerFail;
			ssfSync2 <= ssfSync1;
		end
	end

	// rising edge of each link clock marks one octet
	assign soStrobe = soSync2.linkClk && !soSync3.linkClk; // RULE_01
	assign skStrobe = skSync2.linkClk && !skSync3.linkClk; // RULE_01

	// ----------------------------------------
	// shared decoding
	// ----------------------------------------
	function automatic logic isB2(logic [3:0] r, logic [10:0] c);
		return (r == `STMT_B2_ROW) && (c <= `STMT_B2_LAST_COL);
	endfunction

	function automatic logic isAt(logic [3:0] r, logic [10:0] c, logic [3:0] rr, logic [10:0] cc);
		return (r == rr) && (c == cc);
	endfunction

	function automatic logic [3:0] popCount(logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	function automatic stmt_filt_s filtStep(stmt_filt_s cur, logic match, logic [3:0] need);
		stmt_filt_s r;
		r = cur;
		if (match == cur.flag) begin
			r.cnt = 4'h0;
		end else if (cur.cnt + 4'h1 >= need) begin
			r.flag = match;
			r.cnt = 4'h0;
		end else begin
			r.cnt = cur.cnt + 4'h1;
		end
		return r;
	endfunction

	// ----------------------------------------
	// source
	// ----------------------------------------
	logic [3:0] soRow, soLane;
	logic [10:0] soCol;
	stmt_bip_t soPrev;
	stmt_byte_t soOut, next_soOutData;
	logic next_soOutFrame;
	logic [6:0] remoteErrorCountLink;
	logic remoteDefectLink;
	logic [31:0] ctrl;

	stmt_frame_bip soBip (
		.clk(clk),
		.rst_n(rst_n),
		.strobe(soStrobe),
		.frameStart(soSync2.frame),
		.data(soOut),
		.row(soRow),
		.col(soCol),
		.lane(soLane),
		.prevParity(soPrev)
	);

	always_comb begin
		soOut = soSync2.data;
		if (isB2(soRow, soCol)) begin
			soOut = soPrev[soLane]; // RULE_07
		end else if (isAt(soRow, soCol, `STMT_K2_ROW, `STMT_K2_COL)) begin
			if (remoteDefectLink) begin
				soOut[2:0] = `STMT_K2_RDI; // RULE_03
			end else if (!ctrl[`STMT_CTRL_RING] &&
				(soSync2.data[2:0] == `STMT_K2_AIS || soSync2.data[2:0] == `STMT_K2_RDI)) begin
				soOut[2:0] = `STMT_K2_NORMAL; // RULE_04 RULE_05 RULE_06
			end
		end else if (isAt(soRow, soCol, `STMT_M1_ROW, `STMT_M1_COL)) begin
			soOut = {1'b0, remoteErrorCountLink}; // RULE_02
		end
		next_soOutData = soStrobe ? soOut : soOutData;
		next_soOutFrame = soStrobe ? soSync2.frame : soOutFrame;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soOutData <= 8'h00;
			soOutFrame <= 1'b0;
			soOutStrobe <= 1'b0;
		end else begin
			soOutData <= next_soOutData;
			soOutFrame <= next_soOutFrame;
			soOutStrobe <= soStrobe;
		end
	end

	// ----------------------------------------
	// sink
	// ----------------------------------------
	logic [3:0] skRow, skLane, persist;
	logic [10:0] skCol;
	stmt_bip_t skPrev;
	logic [6:0] errAcc, next_errAcc, next_frameErr, farInc;
	logic nearValid, farValid;
	stmt_filt_s aisFilt, next_aisFilt, rdiFilt, next_rdiFilt;
	stmt_byte_t next_skOutData;
	logic next_skOutFrame;

	stmt_frame_bip skBip (
		.clk(clk),
		.rst_n(rst_n),
		.strobe(skStrobe),
		.frameStart(skSync2.frame),
		.data(skSync2.data),
		.row(skRow),
		.col(skCol),
		.lane(skLane),
		.prevParity(skPrev)
	);

	always_comb begin
		persist = {1'b0, ctrl[`STMT_CTRL_PERSIST_MSB:`STMT_CTRL_PERSIST_LSB]};
		if (persist < {1'b0, `STMT_MIN_PERSIST}) persist = {1'b0, `STMT_MIN_PERSIST}; // RULE_11
		if (persist > {1'b0, `STMT_MAX_PERSIST}) persist = {1'b0, `STMT_MAX_PERSIST}; // RULE_11
		next_errAcc = errAcc;
		next_frameErr = remoteErrorCountLink;
		next_aisFilt = aisFilt;
		next_rdiFilt = rdiFilt;
		nearValid = 1'b0;
		farValid = 1'b0;
		farInc = 7'h00;
		if (skStrobe && isB2(skRow, skCol)) begin
			next_errAcc = errAcc + {3'h0, popCount(skSync2.data ^ skPrev[skLane])}; // RULE_08
			if (skCol == `STMT_B2_LAST_COL) begin
				next_frameErr = next_errAcc; // RULE_02
				next_errAcc = 7'h00;
				nearValid = 1'b1;
			end
		end
		if (skStrobe && isAt(skRow, skCol, `STMT_K2_ROW, `STMT_K2_COL)) begin
			next_aisFilt = filtStep(aisFilt, skSync2.data[2:0] == `STMT_K2_AIS, persist); // RULE_11
			next_rdiFilt = filtStep(rdiFilt, skSync2.data[2:0] == `STMT_K2_RDI, persist); // RULE_10
		end
		if (skStrobe && isAt(skRow, skCol, `STMT_M1_ROW, `STMT_M1_COL)) begin
			farValid = 1'b1;
			farInc = (skSync2.data[6:0] > `STMT_MAX_REI) ? 7'h00 : skSync2.data[6:0]; // RULE_09
		end
		next_skOutData = skStrobe ? (aisFilt.flag ? `STMT_ALL_ONES : skSync2.data) : skOutData; // RULE_12
		next_skOutFrame = skStrobe ? skSync2.frame : skOutFrame;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			errAcc <= 7'h00;
			remoteErrorCountLink <= 7'h00;
			aisFilt <= '0;
			rdiFilt <= '0;
			skOutData <= 8'h00;
			skOutFrame <= 1'b0;
			skOutStrobe <= 1'b0;
		end else begin
			errAcc <= next_errAcc;
			remoteErrorCountLink <= next_frameErr;
			aisFilt <= next_aisFilt;
			rdiFilt <= next_rdiFilt;
			skOutData <= next_skOutData;
			skOutFrame <= next_skOutFrame;
			skOutStrobe <= skStrobe;
		end
	end

	assign remoteDefectLink = aisFilt.flag; // RULE_15

	// ----------------------------------------
	// performance monitoring
	// ----------------------------------------
	logic [31:0] secCnt, next_secCnt, nearAcc, next_nearAcc, farAcc, next_farAcc, degCfg;
	logic [31:0] nearSum, farSum, pmNear, next_pmNear, pmFar, next_pmFar;
	logic nearDsSeen, next_nearDsSeen, farDsSeen, next_farDsSeen, pmNearDs, next_pmNearDs;
	logic pmFarDs, next_pmFarDs, oneSecondTick, badSecond;
	stmt_filt_s degFilt, next_degFilt;

	always_comb begin
		oneSecondTick = (secCnt == SEC_LAST); // RULE_16
		next_secCnt = oneSecondTick ? 32'h00000000 : secCnt + 32'h00000001;
		nearSum = nearAcc + (nearValid ? {25'h0000000, next_frameErr} : 32'h00000000);
		farSum = farAcc + (farValid ? {25'h0000000, farInc} : 32'h00000000);
		badSecond = nearSum >= {16'h0000, degCfg[`STMT_DEG_THR_MSB:0]};
		next_nearAcc = oneSecondTick ? 32'h00000000 : nearSum; // RULE_14
		next_farAcc = oneSecondTick ? 32'h00000000 : farSum; // RULE_14
		next_nearDsSeen = oneSecondTick ? 1'b0 : (nearDsSeen || trailFailAction);
		next_farDsSeen = oneSecondTick ? 1'b0 : (farDsSeen || rdiFilt.flag);
		next_pmNear = oneSecondTick ? nearSum : pmNear;
		next_pmFar = oneSecondTick ? farSum : pmFar;
		next_pmNearDs = oneSecondTick ? (nearDsSeen || trailFailAction) : pmNearDs; // RULE_14
		next_pmFarDs = oneSecondTick ? (farDsSeen || rdiFilt.flag) : pmFarDs; // RULE_14
		next_degFilt = oneSecondTick ?
			filtStep(degFilt, badSecond, degCfg[`STMT_DEG_WIN_MSB:`STMT_DEG_WIN_LSB]) : degFilt; // RULE_16
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secCnt <= 32'h00000000;
			nearAcc <= 32'h00000000;
			farAcc <= 32'h00000000;
			nearDsSeen <= 1'b0;
			farDsSeen <= 1'b0;
			pmNear <= 32'h00000000;
			pmFar <= 32'h00000000;
			pmNearDs <= 1'b0;
			pmFarDs <= 1'b0;
			degFilt <= '0;
		end else begin
			secCnt <= next_secCnt;
			nearAcc <= next_nearAcc;
			farAcc <= next_farAcc;
			nearDsSeen <= next_nearDsSeen;
			farDsSeen <= next_farDsSeen;
			pmNear <= next_pmNear;
			pmFar <= next_pmFar;
			pmNearDs <= next_pmNearDs;
			pmFarDs <= next_pmFarDs;
			degFilt <= next_degFilt;
		end
	end

	// ----------------------------------------
	// registers, reports and interrupt
	// ----------------------------------------
	logic [31:0] next_ctrl, next_degCfg, next_prdata;
	logic [`STMT_IRQ_MSB:0] irqSts, next_irqSts, irqMask, next_irqMask, events, w1c;
	logic aisRep, next_aisRep, degRep, next_degRep, rdiRep, next_rdiRep, ssfRep, next_ssfRep;
	logic next_trailFail, next_trailDegrade, next_irq, next_pslverr, setup, wr;

	always_comb begin
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		next_ctrl = (wr && paddr == `STMT_ADDR_CTRL) ? pwdata : ctrl;
		next_degCfg = (wr && paddr == `STMT_ADDR_DEG) ? pwdata : degCfg;
		next_irqMask = (wr && paddr == `STMT_ADDR_MASK) ? pwdata[`STMT_IRQ_MSB:0] : irqMask;
		w1c = (wr && paddr == `STMT_ADDR_IRQ) ? pwdata[`STMT_IRQ_MSB:0] : '0;
		events = '0;
		events[`STMT_IRQ_SECOND] = oneSecondTick;
		events[`STMT_IRQ_AIS] = next_aisFilt.flag != aisFilt.flag;
		events[`STMT_IRQ_RDI] = next_rdiFilt.flag != rdiFilt.flag;
		events[`STMT_IRQ_DEG] = next_degFilt.flag != degFilt.flag;
		next_irqSts = (irqSts & ~w1c) | events;
		next_irq = |(next_irqSts & irqMask);
		next_aisRep = ctrl[`STMT_CTRL_MON] && aisFilt.flag && !ssfSync2 && ctrl[`STMT_CTRL_AIS_REP]; // RULE_13
		next_degRep = ctrl[`STMT_CTRL_MON] && degFilt.flag; // RULE_13
		next_rdiRep = ctrl[`STMT_CTRL_MON] && rdiFilt.flag && ctrl[`STMT_CTRL_RDI_REP]; // RULE_13
		next_ssfRep = ctrl[`STMT_CTRL_MON] && aisFilt.flag && ctrl[`STMT_CTRL_SSF_REP]; // RULE_13
		next_trailFail = aisFilt.flag; // RULE_15
		next_trailDegrade = degFilt.flag; // RULE_15
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup) begin
			next_pslverr = 1'b0;
			unique case (paddr)
				`STMT_ADDR_CTRL: next_prdata = ctrl;
				`STMT_ADDR_DEG: next_prdata = degCfg;
				`STMT_ADDR_STATUS: next_prdata = {23'h000000, trailDegradeAction, trailFailAction, ssfRep,
					rdiRep, degRep, aisRep, degFilt.flag, rdiFilt.flag, aisFilt.flag};
				`STMT_ADDR_NEAR_EBC: next_prdata = pmNear;
				`STMT_ADDR_FAR_EBC: next_prdata = pmFar;
				`STMT_ADDR_DS: next_prdata = {30'h00000000, pmFarDs, pmNearDs};
				`STMT_ADDR_IRQ: next_prdata = {28'h0000000, irqSts};
				`STMT_ADDR_MASK: next_prdata = {28'h0000000, irqMask};
				default: begin
					next_prdata = 32'h00000000;
					next_pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `STMT_CTRL_RESET;
			degCfg <= `STMT_DEG_RESET;
			irqSts <= '0;
			irqMask <= '0;
			irq <= 1'b0;
			aisRep <= 1'b0;
			degRep <= 1'b0;
			rdiRep <= 1'b0;
			ssfRep <= 1'b0;
			trailFailAction <= 1'b0;
			trailDegradeAction <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			degCfg <= next_degCfg;
			irqSts <= next_irqSts;
			irqMask <= next_irqMask;
			irq <= next_irq;
			aisRep <= next_aisRep;
			degRep <= next_degRep;
			rdiRep <= next_rdiRep;
			ssfRep <= next_ssfRep;
			trailFailAction <= next_trailFail;
			trailDegradeAction <= next_trailDegrade;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	assign pready = 1'b1;
endmodule

// File: dv/stmt_ms_trail_properties.sv
module stmt_ms_trail_properties (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// streams
	input stmt_pkg::stmt_byte_t soOutData,
	input wire logic soOutFrame,
	input wire logic soOutStrobe,
	input stmt_pkg::stmt_byte_t skOutData,
	input wire logic skOutFrame,
	input wire logic skOutStrobe,
	input wire logic trailFailAction
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int K2_POS = 4 * 1080 + 24;
	localparam int M1_POS = 8 * 1080 + 14;
	int soPos, next_soPos;
	logic ringMode, next_ringMode;
	// ----
	// octet position and ring mode tracking
	// ----
	always_comb begin
		next_soPos = soPos;
		next_ringMode = ringMode;
		if (soOutStrobe) begin
			next_soPos = soOutFrame ? 0 : soPos + 1;
		end
		if (psel && penable && pwrite && paddr == 8'h00) begin
			next_ringMode = pwdata[1];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soPos <= 0;
			ringMode <= 1'b0;
		end else begin
			soPos <= next_soPos;
			ringMode <= next_ringMode;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence soAtK2; soOutStrobe && next_soPos == K2_POS; endsequence
	sequence soAtM1; soOutStrobe && next_soPos == M1_POS; endsequence
	sequence alarmHeld; trailFailAction && $past(trailFailAction, 8); endsequence
	sequence alarmGone; !trailFailAction && !$past(trailFailAction, 8) && !ringMode; endsequence
	a_so_strobe_gap: assert property (soOutStrobe |=> !soOutStrobe [*3])
		else $error("source strobes too close");
	a_sk_strobe_gap: assert property (skOutStrobe |=> !skOutStrobe [*3])
		else $error("sink strobes too close");
	a_so_octet_hold: assert property (!soOutStrobe |-> $stable(soOutFrame) && $stable(soOutData))
		else $error("source octet changed without strobe");
	a_sk_frame_hold: assert property (!skOutStrobe |-> $stable(skOutFrame))
		else $error("sink frame flag changed without strobe");
	a_m1_range: assert property (soAtM1 |-> soOutData <= 8'h60)
		else $error("error count above range");
	a_k2_remote: assert property (alarmHeld ##0 soAtK2 |-> soOutData[2:0] == 3'h6)
		else $error("remote defect code missing");
	a_k2_no_ais: assert property (alarmGone ##0 soAtK2 |-> soOutData[2:0] != 3'h7 && soOutData[2:0] != 3'h6)
		else $error("forbidden code sent");
	a_ais_ones: assert property (alarmHeld ##0 skOutStrobe |-> skOutData == 8'hFF)
		else $error("sink data not all ones");
endmodule

bind stmt_ms_trail stmt_ms_trail_properties u_props (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .soOutData(soOutData), .soOutFrame(soOutFrame),
	.soOutStrobe(soOutStrobe), .skOutData(skOutData), .skOutFrame(skOutFrame), .skOutStrobe(skOutStrobe),
	.trailFailAction(trailFailAction));

// File: dv/stmt_link_gen.sv
module stmt_link_gen import stmt_pkg::*; (
	// control
	input wire logic run,
	input wire logic [2:0] k2Code,
	input wire logic [7:0] m1Val,
	input wire logic b2Flip,
	// stream
	output stmt_pkg::stmt_link_s link
);
	timeunit 1ns;
	timeprecision 100ps;
	stmt_bip_t par, prev;
	stmt_byte_t b;
	int pos, col;
	// ----
	// framed octet source, clock runs only once started
	// ----
	initial begin
		link = '0;
		par = '0;
		prev = '0;
		pos = 0;
		wait (run);
		#3.3;
		forever begin
			col = pos % 1080;
			if (pos == 0) begin
				prev = par;
				par = '0;
			end
			b = 8'h5A ^ pos[7:0];
			if (pos / 1080 == 4 && col < 12) b = prev[col] ^ {7'h00, b2Flip && col == 0};
			if (pos == 4 * 1080 + 24) b = {5'h00, k2Code};
			if (pos == 8 * 1080 + 14) b = m1Val;
			if (pos / 1080 > 2 || col > 35) par[col % 12] = par[col % 12] ^ b;
			link.linkClk = 1'b0;
			link.frame = (pos == 0);
			link.data = b;
			#100;
			link.linkClk = 1'b1;
			#100;
			pos = (pos + 1) % 9720;
		end
	end
endmodule

// File: dv/stmt_ms_trail_tb.sv
module stmt_ms_trail_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import stmt_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	stmt_link_s soLink, skLink;
	logic incomingServerFail, soOutFrame, soOutStrobe, skOutFrame, skOutStrobe;
	logic trailFailAction, trailDegradeAction, run, b2Flip;
	logic [2:0] soK2;
	stmt_byte_t soOutData, skOutData;
	int num_errors, checks, sFrm, sPos;
	stmt_bip_t curP, prevP;
	logic [2:0] k2Out [8];
	stmt_byte_t m1Out [8];
	// ----
	// design, far side and clock
	// ----
	stmt_ms_trail #(.SECOND_CYCLES(100000)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .soInLink(soLink), .soOutData(soOutData), .soOutFrame(soOutFrame), .soOutStrobe(soOutStrobe),
		.skInLink(skLink), .incomingServerFail(incomingServerFail), .skOutData(skOutData), .skOutFrame(skOutFrame),
		.skOutStrobe(skOutStrobe), .trailFailAction(trailFailAction), .trailDegradeAction(trailDegradeAction));
	stmt_link_gen soGen (.run(run), .k2Code(soK2), .m1Val(8'h33), .b2Flip(1'b0), .link(soLink));
	stmt_link_gen skGen (.run(run), .k2Code(3'h7), .m1Val(8'hE1), .b2Flip(b2Flip), .link(skLink));
	always #12.5 clk = ~clk;
	// ----
	// tasks
	// ----
	task automatic conclude();
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic apbWr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apbXfer(1'b1, a, d, rd, err);
	endtask
	task automatic apbRd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] rd;
		logic err;
		apbXfer(1'b0, a, 32'h0, rd, err);
		check(rd, exp);
		check(err, expErr);
	endtask
	task automatic waitSo(input int n);
		int k;
		for (k = 0; k < 200000 && sFrm < n; k++) @(posedge clk);
		if (sFrm < n) begin
			num_errors++;
			conclude();
		end
	endtask
	// ----
	// source output monitor
	// ----
	always @(posedge clk) begin
		if (rst_n && soOutStrobe) begin
			if (soOutFrame) begin
				sFrm = sFrm + 1;
				sPos = 0;
				prevP = curP;
				curP = '0;
			end else begin
				sPos = sPos + 1;
			end
			if (sFrm >= 1 && sFrm < 8 && sPos / 1080 == 4 && sPos % 1080 < 12) check(soOutData, prevP[sPos % 1080]);
			if (sPos / 1080 > 2 || sPos % 1080 > 35) curP[sPos % 1080 % 12] ^= soOutData;
			if (sFrm >= 0 && sFrm < 8 && sPos == 4 * 1080 + 24) k2Out[sFrm] = soOutData[2:0];
			if (sFrm >= 0 && sFrm < 8 && sPos == 8 * 1080 + 14) m1Out[sFrm] = soOutData;
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		incomingServerFail = 1'b0;
		run = 1'b0;
		b2Flip = 1'b0;
		soK2 = 3'h7;
		sFrm = -1;
		sPos = 0;
		curP = '0;
		prevP = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		apbRd(8'h00, 32'h0000031D, 1'b0);
		apbRd(8'h04, 32'h00030010, 1'b0);
		apbRd(8'h08, 32'h00000000, 1'b0);
		apbRd(8'h18, 32'h00000000, 1'b0);
		apbRd(8'h22, 32'h00000000, 1'b1);
		apbWr(8'h1C, 32'h0000000F);
		apbRd(8'h1C, 32'h0000000F, 1'b0);
		run <= 1'b1;
		waitSo(1);
		b2Flip <= 1'b1;
		soK2 <= 3'h5;
		waitSo(2);
		b2Flip <= 1'b0;
		soK2 <= 3'h7;
		waitSo(4);
		check(k2Out[0], 3'h0);
		check(k2Out[1], 3'h5);
		check(k2Out[2], 3'h0);
		check(k2Out[3], 3'h6);
		check(m1Out[1], 8'h01);
		check(m1Out[2], 8'h00);
		check(trailFailAction, 1'b1);
		check(trailDegradeAction, 1'b0);
		check(irq, 1'b1);
		apbRd(8'h08, 32'h000000C9, 1'b0);
		apbRd(8'h10, 32'h00000000, 1'b0);
		apbRd(8'h14, 32'h00000001, 1'b0);
		apbWr(8'h1C, 32'h00000000);
		apbWr(8'h18, 32'h0000000F);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		apbWr(8'h1C, 32'h00000002);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		incomingServerFail <= 1'b1;
		repeat (8) @(posedge clk);
		apbRd(8'h08, 32'h000000C1, 1'b0);
		apbWr(8'h00, 32'h0000031C);
		apbRd(8'h08, 32'h00000081, 1'b0);
		conclude();
	end
endmodule
